// *** rtctas_regs.vh ***
// Purpose: register map, field positions and timing counts of the clock
// Assumes: 32-bit Avalon-MM word addresses, 50 MHz system clock
// Notes: included by the timekeeping core and its tick divider
`ifndef RTCTAS_REGS_VH
`define RTCTAS_REGS_VH

// ==========================================================
// Register byte offsets
`define RTCTAS_OFF_TIME 6'h00
`define RTCTAS_OFF_DAY 6'h04
`define RTCTAS_OFF_CTRL 6'h08
`define RTCTAS_OFF_STAT 6'h0C
`define RTCTAS_OFF_IEN 6'h10
`define RTCTAS_OFF_ALM1 6'h14
`define RTCTAS_OFF_ALM2T 6'h18
`define RTCTAS_OFF_ALM2D 6'h1C
`define RTCTAS_OFF_SWLOAD 6'h20
`define RTCTAS_OFF_SWCNT 6'h24
`define RTCTAS_OFF_WKEN 6'h28

// ==========================================================
// Time word fields: seconds [5:0], minutes [13:8], hours [20:16]
`define RTCTAS_SEC_LSB 0
`define RTCTAS_MIN_LSB 8
`define RTCTAS_HR_LSB 16

// ==========================================================
// Control bits
`define RTCTAS_CTRL_RUN 0
`define RTCTAS_CTRL_ALM1 1
`define RTCTAS_CTRL_ALM2 2
`define RTCTAS_CTRL_SW 3
`define RTCTAS_CTRL_RST 32'h0000_0001

// ==========================================================
// Event bits in status, enable and wake registers
`define RTCTAS_EV_SEC 0
`define RTCTAS_EV_MIN 1
`define RTCTAS_EV_HR 2
`define RTCTAS_EV_DAY 3
`define RTCTAS_EV_ALM1 4
`define RTCTAS_EV_ALM2 5
`define RTCTAS_EV_SW 6
`define RTCTAS_EV_W 7

// ==========================================================
// Counter limits and timing
`define RTCTAS_SEC_MAX 6'h3B
`define RTCTAS_MIN_MAX 6'h3B
`define RTCTAS_HR_MAX 5'h17
`define RTCTAS_XTAL_HZ 32768
`define RTCTAS_TICK_HZ 1
`define RTCTAS_XTAL_DIV (`RTCTAS_XTAL_HZ / `RTCTAS_TICK_HZ)
`define RTCTAS_XTAL_LAST 15'h7FFF

`endif

// *** rtctas_prescaler.v ***
// Purpose: divides the crystal-rate enable down to a one-second pulse
// Assumes: xtalEn is a one-cycle pulse at crystal rate
// Notes: counter restarts while run is low
`include "rtctas_regs.vh"

module rtctas_prescaler (
   input wire sys_clk,
   input wire rstn,
   input wire run,
   input wire xtalEn,
   output reg secTick
);

   reg [14:0] div_ff;
   wire [14:0] lastCnt;

   assign lastCnt = `RTCTAS_XTAL_LAST;

   // ==========================================================
   // Crystal divider
   always @(posedge sys_clk) begin
      if (!rstn) begin
         div_ff <= 15'h0000;
         secTick <= 1'b0;
      end else if (!run) begin
         div_ff <= 15'h0000;
         secTick <= 1'b0;
      end else begin
         secTick <= 1'b0;
         if (xtalEn) begin
            if (div_ff == lastCnt) begin
               div_ff <= 15'h0000;
               secTick <= 1'b1;
            end else begin
               div_ff <= div_ff + 15'h0001;
            end
         end
      end
   end

endmodule // rtctas_prescaler

// *** rtctas_core.v ***
// Purpose: time-of-day clock with two alarms, stopwatch and tick events
// Assumes: xtalEn is a crystal-rate enable from the always-on domain
// Notes: Avalon-MM slave, one wait state on every access
`include "rtctas_regs.vh"

module rtctas_core (
   input wire sys_clk,
   input wire rstn,
   input wire xtalEn,
   input wire [3:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   output reg [31:0] avs_readdata,
   output reg avs_waitrequest,
   output reg irq,
   output reg wakeSleep,
   output reg wakeDeep
);

   localparam ST_IDLE = 2'b01;
   localparam ST_DONE = 2'b10;

   reg [1:0] state_ff;
   reg [5:0] sec_ff;
   reg [5:0] min_ff;
   reg [4:0] hr_ff;
   reg [14:0] day_ff;
   reg [31:0] ctrl_ff;
   reg [6:0] stat_ff;
   reg [6:0] ien_ff;
   reg [6:0] wken_ff;
   reg [20:0] alm1_ff;
   reg [20:0] alm2t_ff;
   reg [14:0] alm2d_ff;
   reg [15:0] swLoad_ff;
   reg [15:0] swCnt_ff;
   reg swLive_ff;
   reg almSeen_ff;
   reg [6:0] nxt_stat;
   reg [31:0] nxt_rdata;
   wire secTick;
   wire secWrap;
   wire minWrap;
   wire hrWrap;
   wire [20:0] curTime;
   wire alm1Hit;
   wire alm2Hit;
   wire swUnder;
   wire [6:0] events;
   wire [5:0] regAddr;
   wire busWr;
   wire [31:0] wmask;
   wire [6:0] clrBits;

   // ==========================================================
   // One-second tick
   rtctas_prescaler uPre (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .run(ctrl_ff[`RTCTAS_CTRL_RUN]),
      .xtalEn(xtalEn),
      .secTick(secTick)
   );

   // ==========================================================
   // Bus decode
   assign regAddr = {avs_address, 2'b00};
   assign busWr = avs_write && (state_ff == ST_DONE);
   assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                   {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   assign clrBits = (busWr && regAddr == `RTCTAS_OFF_STAT) ?
                    (avs_writedata[6:0] & wmask[6:0]) : 7'h00;

   // ==========================================================
   // Time counters
   assign secWrap = secTick && (sec_ff == `RTCTAS_SEC_MAX);
   assign minWrap = secWrap && (min_ff == `RTCTAS_MIN_MAX);
   assign hrWrap = minWrap && (hr_ff == `RTCTAS_HR_MAX);
   assign curTime = {hr_ff, 2'b00, min_ff, 2'b00, sec_ff};

   always @(posedge sys_clk) begin
      if (!rstn) begin
         sec_ff <= 6'h00;
         min_ff <= 6'h00;
         hr_ff <= 5'h00;
         day_ff <= 15'h0000;
      end else if (busWr && regAddr == `RTCTAS_OFF_TIME) begin
         sec_ff <= avs_writedata[5:0];
         min_ff <= avs_writedata[13:8];
         hr_ff <= avs_writedata[20:16];
      end else if (busWr && regAddr == `RTCTAS_OFF_DAY) begin
         day_ff <= avs_writedata[14:0];
      end else if (secTick) begin
         sec_ff <= secWrap ? 6'h00 : sec_ff + 6'h01;
         if (secWrap) begin
            min_ff <= minWrap ? 6'h00 : min_ff + 6'h01;
         end
         if (minWrap) begin
            hr_ff <= hrWrap ? 5'h00 : hr_ff + 5'h01;
         end
         if (hrWrap) begin
            day_ff <= day_ff + 15'h0001;
         end
      end
   end

   // ==========================================================
   // Alarms, compared once per second after the count settles
   assign alm1Hit = ctrl_ff[`RTCTAS_CTRL_ALM1] &&
                    (curTime == alm1_ff);
   assign alm2Hit = ctrl_ff[`RTCTAS_CTRL_ALM2] &&
                    (curTime == alm2t_ff) && (day_ff == alm2d_ff);

   always @(posedge sys_clk) begin
      if (!rstn) begin
         almSeen_ff <= 1'b0;
      end else begin
         almSeen_ff <= secTick;
      end
   end

   // ==========================================================
   // Stopwatch
   assign swUnder = secTick && swLive_ff && (swCnt_ff == 16'h0000);

   always @(posedge sys_clk) begin
      if (!rstn) begin
         swCnt_ff <= 16'h0000;
         swLive_ff <= 1'b0;
      end else if (busWr && regAddr == `RTCTAS_OFF_SWLOAD) begin
         swCnt_ff <= avs_writedata[15:0];
         swLive_ff <= 1'b1;
      end else if (secTick && ctrl_ff[`RTCTAS_CTRL_SW] && swLive_ff) begin
         if (swCnt_ff == 16'h0000) begin
            swLive_ff <= 1'b0;
         end else begin
            swCnt_ff <= swCnt_ff - 16'h0001;
         end
      end
   end

   // ==========================================================
   // Sticky status, set wins over clear
   assign events = {swUnder && ctrl_ff[`RTCTAS_CTRL_SW],
                    almSeen_ff && alm2Hit,
                    almSeen_ff && alm1Hit,
                    hrWrap, minWrap, secWrap, secTick};

   always @* begin
      nxt_stat = (stat_ff & ~clrBits) | events;
   end

   // ==========================================================
   // Control registers
   always @(posedge sys_clk) begin
      if (!rstn) begin
         ctrl_ff <= `RTCTAS_CTRL_RST;
         ien_ff <= 7'h00;
         wken_ff <= 7'h00;
         alm1_ff <= 21'h000000;
         alm2t_ff <= 21'h000000;
         alm2d_ff <= 15'h0000;
         swLoad_ff <= 16'h0000;
         stat_ff <= 7'h00;
      end else begin
         stat_ff <= nxt_stat;
         if (busWr) begin
            case (regAddr)
               `RTCTAS_OFF_CTRL: begin
                  ctrl_ff <= (ctrl_ff & ~wmask) | (avs_writedata & wmask);
               end
               `RTCTAS_OFF_IEN: begin
                  ien_ff <= avs_writedata[6:0];
               end
               `RTCTAS_OFF_WKEN: begin
                  wken_ff <= avs_writedata[6:0];
               end
               `RTCTAS_OFF_ALM1: begin
                  alm1_ff <= avs_writedata[20:0] & 21'h1F3F3F;
               end
               `RTCTAS_OFF_ALM2T: begin
                  alm2t_ff <= avs_writedata[20:0] & 21'h1F3F3F;
               end
               `RTCTAS_OFF_ALM2D: begin
                  alm2d_ff <= avs_writedata[14:0];
               end
               `RTCTAS_OFF_SWLOAD: begin
                  swLoad_ff <= avs_writedata[15:0];
               end
               default: begin
               end
            endcase
         end
      end
   end

   // ==========================================================
   // Interrupt and wake outputs
   always @(posedge sys_clk) begin
      if (!rstn) begin
         irq <= 1'b0;
         wakeSleep <= 1'b0;
         wakeDeep <= 1'b0;
      end else begin
         irq <= |(nxt_stat & ien_ff);
         wakeSleep <= |(nxt_stat & wken_ff);
         wakeDeep <= |(nxt_stat & wken_ff);
      end
   end

   // ==========================================================
   // Read mux
   always @* begin
      case (regAddr)
         `RTCTAS_OFF_TIME: nxt_rdata = {11'h000, curTime};
         `RTCTAS_OFF_DAY: nxt_rdata = {17'h00000, day_ff};
         `RTCTAS_OFF_CTRL: nxt_rdata = ctrl_ff;
         `RTCTAS_OFF_STAT: nxt_rdata = {25'h0000000, stat_ff};
         `RTCTAS_OFF_IEN: nxt_rdata = {25'h0000000, ien_ff};
         `RTCTAS_OFF_ALM1: nxt_rdata = {11'h000, alm1_ff};
         `RTCTAS_OFF_ALM2T: nxt_rdata = {11'h000, alm2t_ff};
         `RTCTAS_OFF_ALM2D: nxt_rdata = {17'h00000, alm2d_ff};
         `RTCTAS_OFF_SWLOAD: nxt_rdata = {16'h0000, swLoad_ff};
         `RTCTAS_OFF_SWCNT: nxt_rdata = {15'h0000, swLive_ff, swCnt_ff};
         `RTCTAS_OFF_WKEN: nxt_rdata = {25'h0000000, wken_ff};
         default: nxt_rdata = 32'h0000_0000;
      endcase
   end

   // ==========================================================
   // Bus handshake, one wait state
   always @(posedge sys_clk) begin
      if (!rstn) begin
         state_ff <= ST_IDLE;
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0000_0000;
      end else begin
         case (state_ff)
            ST_IDLE: begin
               if (avs_read || avs_write) begin
                  state_ff <= ST_DONE;
                  avs_waitrequest <= 1'b0;
                  if (avs_read) begin
                     avs_readdata <= nxt_rdata;
                  end
               end
            end
            ST_DONE: begin
               state_ff <= ST_IDLE;
               avs_waitrequest <= 1'b1;
            end
            default: begin
               state_ff <= ST_IDLE;
               avs_waitrequest <= 1'b1;
            end
         endcase
      end
   end

endmodule // rtctas_core

// *** rtctas_core_assertions.sv ***
// Purpose: port checks for the clock core
// Assumes: sees only the top module ports
// Notes: bound into rtctas_core
module rtctas_core_chk (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic wakeSleep,
   input wire logic wakeDeep,
   input wire logic irq
);
   // ==========================================================
   // Bus and output checks
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rstn);
   wire rdTake = avs_read && avs_waitrequest;
   property p_ans;
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
   endproperty
   a_ans: assert property (p_ans) else $error("no bus answer");
   property p_one;
      !avs_waitrequest |=> avs_waitrequest;
   endproperty
   a_one: assert property (p_one) else $error("answer too long");
   property p_idle;
      !avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest;
   endproperty
   a_idle: assert property (p_idle) else $error("answer without request");
   property p_rst;
      disable iff (1'b0) !rstn |=> avs_waitrequest && !irq && !wakeSleep
         && avs_readdata == 32'h0;
   endproperty
   a_rst: assert property (p_rst) else $error("bad reset outputs");
   property p_deep;
      wakeDeep == wakeSleep;
   endproperty
   a_deep: assert property (p_deep) else $error("deep wake differs");
   property p_unm;
      rdTake && avs_address > 4'hA |=> avs_readdata == 32'h0;
   endproperty
   a_unm: assert property (p_unm) else $error("unmapped read not zero");
   property p_hold;
      !avs_read |=> $stable(avs_readdata);
   endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   property p_time;
      rdTake && avs_address == 4'h0 |=> avs_readdata[5:0] <= 6'h3B
         && avs_readdata[13:8] <= 6'h3B && avs_readdata[20:16] <= 5'h17;
   endproperty
   a_time: assert property (p_time) else $error("time out of range");
   property p_day;
      rdTake && avs_address == 4'h1 |=> avs_readdata[31:15] == 17'h0;
   endproperty
   a_day: assert property (p_day) else $error("day too wide");
endmodule // rtctas_core_chk

bind rtctas_core rtctas_core_chk u_chk (.sys_clk, .rstn, .avs_address,
   .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .wakeSleep,
   .wakeDeep, .irq);

// *** rtctas_pwr_model.sv ***
// Purpose: power manager model on the wake outputs
// Assumes: state 0 run, 1 sleep, 2 deep sleep
// Notes: sleepReq enters a low-power state
module rtctas_pwr_model (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic [1:0] sleepReq,
   input wire logic wakeSleep,
   input wire logic wakeDeep,
   output logic [1:0] pwrState
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================================
   // Power state
   always @(posedge sys_clk) begin
      if (!rstn)
         pwrState <= 2'h0;
      else if (pwrState == 2'h1 && wakeSleep)
         pwrState <= 2'h0;
      else if (pwrState == 2'h2 && wakeDeep)
         pwrState <= 2'h0;
      else if (sleepReq != 2'h0)
         pwrState <= sleepReq;
   end
endmodule // rtctas_pwr_model

// *** rtctas_core_test.sv ***
// Purpose: self-checking bench for the clock core
// Assumes: xtalEn high every cycle, one second is 32768 cycles
// Notes: bus tasks wait on waitrequest
`include "rtctas_regs.vh"
module rtctas_core_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk, rstn, xtalEn, avs_read, avs_write;
   logic avs_waitrequest, irq, wakeSleep, wakeDeep;
   logic [3:0] avs_address, avs_byteenable;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [1:0] sleepReq, pwrState;
   int error_cnt, compares, cycNow, t0, t1;
   rtctas_core dut (.sys_clk, .rstn, .xtalEn, .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
      .avs_waitrequest, .irq, .wakeSleep, .wakeDeep);
   rtctas_pwr_model pm (.sys_clk, .rstn, .sleepReq, .wakeSleep,
      .wakeDeep, .pwrState);
   // ==========================================================
   // Clock and helpers
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) cycNow <= cycNow + 1;
   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task tally_and_finish;
      $display("compares %0d errors %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      do begin
         @(posedge sys_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge sys_clk);
      if (n >= 50) begin
         error_cnt++;
         tally_and_finish();
      end
   endtask
   task wr(input logic [3:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task rchk(input logic [3:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   task wait_irq(output int t);
      int n;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (irq !== 1'b1 && n < 40000);
      t = cycNow;
      if (n >= 40000) begin
         error_cnt++;
         tally_and_finish();
      end
   endtask
   task doze(input logic [1:0] s);
      sleepReq <= s;
      @(posedge sys_clk);
      sleepReq <= 2'h0;
   endtask
   // ==========================================================
   // Scenarios
   task t_reset;
      rchk(4'h2, 32'h1);
      rchk(4'h3, 32'h0);
      wr(4'hB, 32'hFFFF_FFFF);
      rchk(4'hB, 32'h0);
      $display("test reset done");
   endtask
   task t_rollover;
      wr(4'h0, 32'h0017_3B3B);
      wr(4'h1, 32'h0000_7FFF);
      wr(4'h5, 32'h0);
      wr(4'h6, 32'h0);
      wr(4'h7, 32'h0);
      wr(4'h8, 32'h1);
      wr(4'h4, 32'h1);
      wr(4'hA, 32'h20);
      wr(4'h2, 32'hF);
      rchk(4'h9, 32'h0001_0001);
      doze(2'h2);
      wait_irq(t0);
      rchk(4'h3, 32'h3F);
      rchk(4'h0, 32'h0);
      rchk(4'h1, 32'h0);
      rchk(4'h9, 32'h0001_0000);
      chk(32'(pwrState), 32'h0);
      wr(4'h3, 32'h7F);
      repeat (2) @(posedge sys_clk);
      chk(32'(irq), 32'h0);
      $display("test rollover done");
   endtask
   task t_second;
      doze(2'h1);
      wait_irq(t1);
      chk(32'(t1 - t0), `RTCTAS_XTAL_DIV);
      rchk(4'h3, 32'h41);
      rchk(4'h0, 32'h1);
      rchk(4'h9, 32'h0);
      chk(32'(pwrState), 32'h1);
      wr(4'hA, 32'h40);
      repeat (3) @(posedge sys_clk);
      chk(32'(pwrState), 32'h0);
      wr(4'h4, 32'h0);
      repeat (2) @(posedge sys_clk);
      chk(32'(irq), 32'h0);
      $display("test second done");
   endtask
   initial begin
      rstn = 1'b0;
      xtalEn = 1'b1;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 4'h0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hF;
      sleepReq = 2'h0;
      error_cnt = 0;
      compares = 0;
      cycNow = 0;
      repeat (6) @(posedge sys_clk);
      rstn <= 1'b1;
      t_reset();
      t_rollover();
      t_second();
      tally_and_finish();
   end
endmodule // rtctas_core_test
